// File: bench/cwd_core_props.sv
/*
 * Checker for the countdown watchdog core: load, tick and expiry timing.
 * Assumes one clock domain and the top module's ports only.
 */
`timescale 1ns/1ps
module cwd_core_props #(
    parameter int COUNT_W = 8,
    parameter int SECOND_CYC = 10
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic svc_req_i,
    input wire logic [7:0] svc_func_i,
    input wire logic [7:0] svc_sub_i,
    input wire logic [COUNT_W-1:0] svc_value_i,
    input wire logic unit_sel_i,
    input wire logic action_sel_i,
    input wire logic svc_ack_o,
    input wire logic running_o,
    input wire logic [COUNT_W-1:0] count_o,
    input wire logic cold_reset_o,
    input wire logic nmi_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    logic acc;
    logic [COUNT_W-1:0] prev_reg;
    int since_reg;
    int unit_cyc;
    assign acc = clk_en_i && svc_req_i && svc_func_i == cwd_pkg::CWD_FUNC_CODE
        && svc_sub_i == cwd_pkg::CWD_SUB_SET_PERIOD;
    assign unit_cyc = unit_sel_i ? SECOND_CYC * cwd_pkg::CWD_MINUTE_S : SECOND_CYC;
    // Enabled cycles since the count last moved; a load restarts the measure
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prev_reg <= '0;
            since_reg <= 0;
        end else begin
            prev_reg <= count_o;
            since_reg <= (svc_ack_o || count_o != prev_reg) ? 0 : since_reg + (clk_en_i ? 1 : 0);
        end
    end
    // Final unit, then zero without a load; pulse shows with the zero
    sequence expire_s(logic act);
        (count_o == 8'h01 && action_sel_i == act) ##1 (count_o == 8'h00 && !svc_ack_o);
    endsequence
    chk_load_taken: assert property (
        acc |=> svc_ack_o && count_o == $past(svc_value_i)
        && running_o == ($past(svc_value_i) != '0)) else $error("load not taken");
    chk_other_codes: assert property (
        !acc |=> !svc_ack_o) else $error("ack without load");
    chk_idle_holds: assert property (
        !running_o && !acc |=> !running_o) else $error("idle left");
    chk_count_step: assert property (
        running_o && !acc |=> count_o == $past(count_o)
        || count_o == $past(count_o) - 8'h01) else $error("count jumped");
    chk_tick_spacing: assert property (
        !svc_ack_o && count_o != prev_reg
        |-> since_reg >= unit_cyc - 2 && since_reg <= unit_cyc) else $error("tick spacing off");
    chk_expire_reset: assert property (
        expire_s(1'b0) |-> cold_reset_o && !nmi_o) else $error("no cold reset on expiry");
    chk_expire_nmi: assert property (
        expire_s(1'b1) |-> nmi_o && !cold_reset_o) else $error("no nmi on expiry");
    chk_pulse_single: assert property (
        (cold_reset_o || nmi_o) |=> !(cold_reset_o || nmi_o)) else $error("recovery pulse too long");
endmodule : cwd_core_props
bind cwd_core cwd_core_props #(.COUNT_W(COUNT_W), .SECOND_CYC(SECOND_CYC)) cwd_core_props_i (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .svc_req_i(svc_req_i),
    .svc_func_i(svc_func_i), .svc_sub_i(svc_sub_i), .svc_value_i(svc_value_i),
    .unit_sel_i(unit_sel_i), .action_sel_i(action_sel_i), .svc_ack_o(svc_ack_o),
    .running_o(running_o), .count_o(count_o), .cold_reset_o(cold_reset_o), .nmi_o(nmi_o));

// File: bench/cwd_core_tb.sv
/*
 * Self-checking bench for the countdown watchdog core.
 * Assumes a shortened second of SC cycles; clk_en_i stays high except during the freeze test.
 */
`timescale 1ns/1ps
module cwd_core_tb;
    localparam int SC = 10;
    localparam logic [7:0] FC = cwd_pkg::CWD_FUNC_CODE;
    localparam logic [7:0] SF = cwd_pkg::CWD_SUB_SET_PERIOD;
    logic clock_i = 0, sys_rst_i = 1, clk_en_i = 1, svc_req_i = 0, unit_sel_i = 0, action_sel_i = 0;
    logic [7:0] svc_func_i = 8'h00, svc_sub_i = 8'h00, svc_value_i = 8'h00, count_o;
    logic svc_ack_o, running_o, cold_reset_o, nmi_o;
    int fails = 0;
    int cmp_count = 0;
    logic [9:0] exp_q[$];
    cwd_core #(.SECOND_CYC(SC)) cwd_core_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i), .svc_req_i(svc_req_i), .svc_func_i(svc_func_i), .svc_sub_i(svc_sub_i),
        .svc_value_i(svc_value_i), .unit_sel_i(unit_sel_i), .action_sel_i(action_sel_i),
        .svc_ack_o(svc_ack_o), .running_o(running_o), .count_o(count_o),
        .cold_reset_o(cold_reset_o), .nmi_o(nmi_o));
    initial begin
        forever #2 clock_i = ~clock_i;
    end
    task check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task finish_test;
        if (fails == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    // Request stays up so consecutive calls give back-to-back loads
    task load(input logic [7:0] f, input logic [7:0] s, input logic [7:0] v);
        @(negedge clock_i);
        svc_req_i = 1;
        svc_func_i = f;
        svc_sub_i = s;
        svc_value_i = v;
        if (f == FC && s == SF) exp_q.push_back({2'b00, v});
    endtask : load
    task rel;
        @(negedge clock_i);
        svc_req_i = 0;
        svc_value_i = ~svc_value_i;
    endtask : rel
    task drain(input int n);
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < n) begin
            @(posedge clock_i);
            k++;
        end
        // Return off the edge so callers may change inputs at once
        @(negedge clock_i);
        check("pending", 10'(exp_q.size()), 10'h000);
    endtask : drain
    // Every ack or pulse consumes the oldest note
    always @(posedge clock_i) begin
        logic [9:0] obs;
        #1;
        obs = {cold_reset_o, nmi_o, count_o};
        if (svc_ack_o === 1'b1 || cold_reset_o === 1'b1 || nmi_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected", obs, 10'h3ff);
            end else begin
                check("result", obs, exp_q.pop_front());
            end
        end
    end
    initial begin
        void'($urandom(46695));
        repeat (2) @(posedge clock_i);
        @(negedge clock_i) sys_rst_i = 0;
        check("reset", {running_o, 1'b0, count_o}, 10'h000);
        load(8'h6e, SF, 8'h05);
        load(FC, 8'h01, 8'h05);
        load(FC, 8'h03, 8'h05);
        rel;
        repeat (3) @(negedge clock_i);
        check("wrong code", {running_o, 1'b0, count_o}, 10'h000);
        load(FC, SF, 8'h03);
        load(FC, SF, 8'h00);
        rel;
        repeat (5 * SC) @(negedge clock_i);
        check("zero load", {running_o, 1'b0, count_o}, 10'h000);
        // Refresh every SC + 1 cycles, well inside the shortest period
        repeat (6) begin
            load(FC, SF, 8'(2 + $urandom % 3));
            rel;
            repeat (SC) @(posedge clock_i);
        end
        exp_q.push_back(10'h200);
        drain(5 * SC);
        // Freeze over the first step; the count must resume where it stopped
        load(FC, SF, 8'h03);
        exp_q.push_back(10'h200);
        rel;
        repeat (SC) @(negedge clock_i);
        clk_en_i = 0;
        repeat (5 * SC) @(negedge clock_i);
        check("frozen", {running_o, 1'b0, count_o}, 10'h203);
        clk_en_i = 1;
        drain(4 * SC);
        action_sel_i = 1;
        load(FC, SF, 8'h01);
        exp_q.push_back(10'h100);
        rel;
        drain(3 * SC);
        action_sel_i = 0;
        unit_sel_i = 1;
        load(FC, SF, 8'h01);
        exp_q.push_back(10'h200);
        rel;
        repeat (60 * SC - 5) @(negedge clock_i);
        check("minute", {running_o, 1'b0, count_o}, 10'h201);
        drain(20);
        unit_sel_i = 0;
        load(FC, SF, 8'hff);
        exp_q.push_back(10'h200);
        rel;
        drain(256 * SC + 10);
        // Disable before the run ends, as supervising software must
        load(FC, SF, 8'h02);
        load(FC, SF, 8'h00);
        rel;
        repeat (4 * SC) @(negedge clock_i);
        check("disabled", {running_o, 1'b0, count_o}, 10'h000);
        finish_test();
    end
    initial begin
        #100000;
        fails++;
        finish_test();
    end
endmodule : cwd_core_tb

// File: hw/cwd_core.sv
/*
 * Countdown watchdog core: takes period loads from the firmware service path,
 * counts down in configured units and raises a recovery pulse on expiry.
 * Assumes all inputs are synchronous to clock_i; unit and action selects are static setup.
 */
`timescale 1ns/1ps
module cwd_core #(
    parameter int COUNT_W = cwd_pkg::CWD_COUNT_W,
    parameter int SECOND_CYC = cwd_pkg::CWD_SECOND_CYC
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // Firmware service request
    input wire logic svc_req_i,
    input wire logic [7:0] svc_func_i,
    input wire logic [7:0] svc_sub_i,
    input wire logic [COUNT_W-1:0] svc_value_i,
    // Setup options
    input wire logic unit_sel_i,
    input wire logic action_sel_i,
    // Status and recovery
    output logic svc_ack_o,
    output logic running_o,
    output logic [COUNT_W-1:0] count_o,
    output logic cold_reset_o,
    output logic nmi_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    cwd_tick_if tick ();
    cwd_pkg::cwd_state_t state_reg;
    cwd_pkg::cwd_state_t state_next;
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] count_next;
    logic load;
    logic expire;
    logic running_reg;
    logic ack_reg;
    logic cold_reg;
    logic nmi_reg;

    function automatic logic is_period_load(input logic [7:0] func, input logic [7:0] sub);
        return (func == cwd_pkg::CWD_FUNC_CODE) && (sub == cwd_pkg::CWD_SUB_SET_PERIOD);
    endfunction : is_period_load

    assign load = svc_req_i && is_period_load(svc_func_i, svc_sub_i);
    // Expiry when the last unit elapses with count at one; a load in that cycle wins
    assign expire = (state_reg == cwd_pkg::CWD_ST_RUN) && tick.unit_tick &&
                    (count_reg == COUNT_W'(1)) && !load;
    // Restart in the load cycle itself so a tick already due cannot eat the new period
    assign tick.restart = load;
    assign tick.unit_sel = cwd_pkg::cwd_unit_t'(unit_sel_i);

    // ------------------------------------------------------------
    // Unit prescaler
    // ------------------------------------------------------------
    cwd_prescaler #(
        .SECOND_CYC(SECOND_CYC),
        .MINUTE_DIV(cwd_pkg::CWD_MINUTE_CYC_DIV)
    ) u_pre (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .tick(tick.pre)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            cwd_pkg::CWD_ST_IDLE: begin
                if (load && (svc_value_i != '0)) begin
                    state_next = cwd_pkg::CWD_ST_RUN;
                end
                if (load) begin
                    count_next = svc_value_i;
                end
            end
            cwd_pkg::CWD_ST_RUN: begin
                if (load) begin
                    count_next = svc_value_i;
                    if (svc_value_i == '0) begin
                        state_next = cwd_pkg::CWD_ST_IDLE;
                    end
                end else if (tick.unit_tick) begin
                    count_next = count_reg - COUNT_W'(1);
                    if (count_reg == COUNT_W'(1)) begin
                        state_next = cwd_pkg::CWD_ST_IDLE;
                    end
                end
            end
            default: begin
                state_next = cwd_pkg::CWD_ST_IDLE;
                count_next = '0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Count and state
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= cwd_pkg::CWD_ST_IDLE;
            count_reg <= COUNT_W'(cwd_pkg::CWD_COUNT_RST);
            running_reg <= 1'b0;
        end else if (clk_en_i) begin
            state_reg <= state_next;
            count_reg <= count_next;
            running_reg <= (state_next == cwd_pkg::CWD_ST_RUN);
        end
    end

    // ------------------------------------------------------------
    // Acknowledge
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ack_reg <= 1'b0;
        end else if (clk_en_i) begin
            ack_reg <= load;
        end
    end

    // ------------------------------------------------------------
    // Recovery outputs
    // ------------------------------------------------------------
    // One-cycle pulses; the system reset tree stretches the cold reset
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cold_reg <= 1'b0;
            nmi_reg <= 1'b0;
        end else if (clk_en_i) begin
            cold_reg <= expire && (action_sel_i == cwd_pkg::CWD_ACT_RESET);
            nmi_reg <= expire && (action_sel_i == cwd_pkg::CWD_ACT_NMI);
        end
    end

    assign svc_ack_o = ack_reg;
    assign running_o = running_reg;
    assign count_o = count_reg;
    assign cold_reset_o = cold_reg;
    assign nmi_o = nmi_reg;

endmodule : cwd_core

// File: hw/cwd_pkg.sv
/*
 * Package for the countdown watchdog: service codes, unit selections, reset values.
 * Assumes a single 250 MHz system clock shared by all users of the package.
 */
package cwd_pkg;

    // ------------------------------------------------------------
    // Service request codes
    // ------------------------------------------------------------
    localparam logic [7:0] CWD_FUNC_CODE = 8'h6f;
    localparam logic [7:0] CWD_SUB_SET_PERIOD = 8'h02;

    // ------------------------------------------------------------
    // Count and timing
    // ------------------------------------------------------------
    localparam int CWD_COUNT_W = 8;
    localparam logic [7:0] CWD_COUNT_RST = 8'h00;
    localparam int CWD_CLK_MHZ = 250;
    localparam int CWD_SECOND_US = 1000000;
    localparam int CWD_MINUTE_S = 60;
    localparam int CWD_SECOND_CYC = CWD_SECOND_US * CWD_CLK_MHZ;
    localparam int CWD_MINUTE_CYC_DIV = CWD_MINUTE_S;

    // ------------------------------------------------------------
    // Time unit selection
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        CWD_UNIT_SECOND = 1'b0,
        CWD_UNIT_MINUTE = 1'b1
    } cwd_unit_t;

    // ------------------------------------------------------------
    // Recovery action selection
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        CWD_ACT_RESET = 1'b0,
        CWD_ACT_NMI = 1'b1
    } cwd_action_t;

    // ------------------------------------------------------------
    // Counter states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CWD_ST_IDLE = 2'b01,
        CWD_ST_RUN = 2'b10
    } cwd_state_t;

endpackage : cwd_pkg

// File: hw/cwd_prescaler.sv
/*
 * Unit prescaler: emits one tick per configured time unit.
 * Assumes restart is pulsed on every load so the first unit is a full one.
 */
`timescale 1ns/1ps
module cwd_prescaler #(
    parameter int SECOND_CYC = cwd_pkg::CWD_SECOND_CYC,
    parameter int MINUTE_DIV = cwd_pkg::CWD_MINUTE_CYC_DIV
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // Tick link
    cwd_tick_if.pre tick
);

    logic [31:0] sec_cnt_reg;
    logic [7:0] min_cnt_reg;
    logic sec_wrap;
    logic tick_reg;

    assign sec_wrap = (sec_cnt_reg == 32'(SECOND_CYC - 1));
    assign tick.unit_tick = tick_reg;

    // ------------------------------------------------------------
    // Second divider
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sec_cnt_reg <= 32'h0000_0000;
        end else if (clk_en_i) begin
            if (tick.restart || sec_wrap) begin
                sec_cnt_reg <= 32'h0000_0000;
            end else begin
                sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Minute divider and tick
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            min_cnt_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else if (clk_en_i) begin
            tick_reg <= 1'b0;
            if (tick.restart) begin
                min_cnt_reg <= 8'h00;
            end else if (sec_wrap) begin
                if (tick.unit_sel == cwd_pkg::CWD_UNIT_SECOND) begin
                    tick_reg <= 1'b1;
                end else if (min_cnt_reg == 8'(MINUTE_DIV - 1)) begin
                    min_cnt_reg <= 8'h00;
                    tick_reg <= 1'b1;
                end else begin
                    min_cnt_reg <= min_cnt_reg + 8'h01;
                end
            end
        end
    end

endmodule : cwd_prescaler

// File: hw/cwd_tick_if.sv
/*
 * Interface carrying the unit tick between the prescaler and the core.
 * Assumes both ends share clock_i.
 */
`timescale 1ns/1ps
interface cwd_tick_if;
    logic restart;
    logic unit_tick;
    cwd_pkg::cwd_unit_t unit_sel;

    modport core (output restart, output unit_sel, input unit_tick);
    modport pre (input restart, input unit_sel, output unit_tick);
endinterface : cwd_tick_if
